/* File: src/bap_unit.sv */
// Bus access policy unit with AXI4-Lite registers.
// Assumes ext_ready ends every started cycle
// and refresh_tick pulses once per refresh.
// Operation
// [RULE_01] ROM reads and DRAM reads/writes accept all six sizes.
// [RULE_02] System bus and first on-chip I/O refuse 3-byte transfers.
// [RULE_03] LCD/fast bus allow 8,4,2,1; second on-chip I/O 8,4,2.
// [RULE_04] Flash writes match bus width: 4 bytes on 32, 2 on 16.
// [RULE_05] LCD and fast bus share one range, one bit selects.
// [RULE_06] Two ROM mode settings: banks 3/2 and banks 1/0.
// [RULE_07] Flash bit set means flash; else page bit picks page-ROM.
// [RULE_08] Ordinary and flash modes read all; page mode page-ROM only.
// [RULE_09] Flash writes and register reads only in flash mode.
// [RULE_10] Reset leaves both bank pairs in ordinary ROM mode.
// [RULE_11] ROM wait programmable except in flash mode, fixed there.
// [RULE_12] Ordinary ROM mode writes keep the write strobe off.
// [RULE_13] Software raises voltage, enters flash mode, then writes.
// [RULE_14] Software checks status, retries, leaves flash mode first.
// [RULE_15] LCD interface accepts 1, 2, 4 and 8 byte transfers.
// [RULE_16] LCD data inverted when select and graphics bits are 0.
// [RULE_17] No ready within two refreshes is deadlock, illegal access. Code times out only system bus, LCD and fast bus cycles.
// [RULE_18] Addresses 0x0C00_0000 to 0x0FFF_FFFF are illegal.
// [RULE_19] Addresses 0x0400_0000 to 0x09FF_FFFF are illegal.
// [RULE_20] Illegal reads end with a bus error response.
// [RULE_21] Illegal writes raise interrupt zero until software clears.
// [RULE_22] Writing 1 to error status bit 1 clears that interrupt.
// [RULE_23] All sequencing runs on the peripheral clock.
// [RULE_24] Illegal accesses start no external cycle or strobe.
// [RULE_25] Refused sizes report through the same illegal paths.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module bap_unit
   import bap_pkg::*;
(
   input wire logic core_clk, // Peripheral clock
   input wire logic rst_n, // Synchronous reset
   input wire logic ce, // Clock enable
   input logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input logic [7:0] s_axi_awaddr, // Write address
   input logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   input logic [31:0] s_axi_wdata, // Write data
   input logic [3:0] s_axi_wstrb, // Byte strobes
   output logic s_axi_bvalid, // Write response valid
   input logic s_axi_bready, // Write response ready
   output logic [1:0] s_axi_bresp, // Write response
   input logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   input logic [7:0] s_axi_araddr, // Read address
   output logic s_axi_rvalid, // Read data valid
   input logic s_axi_rready, // Read data ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   input logic req_valid, // Request valid
   output logic req_ready, // Request taken
   input logic req_write, // Request is a write
   input logic [31:0] req_addr, // Physical address
   input logic [2:0] req_size, // Size code
   input logic [31:0] req_wdata, // Write data
   output logic rsp_valid, // Core answer pulse
   output logic rsp_err, // Bus error on a refused or timed-out read
   output logic [31:0] rsp_rdata, // Core read data
   output logic core_interrupt_zero, // Illegal write interrupt
   output logic ext_valid, // External cycle in progress
   output logic ext_write, // External cycle is a write
   output logic ext_wr_strobe, // Write strobe allowed
   output logic [3:0] ext_space, // Target space code
   output logic [1:0] ext_rom_mode, // ROM access mode
   output logic [2:0] ext_rom_wait, // ROM wait setting
   output logic ext_wait_prog, // ROM wait is programmable
   output logic [31:0] ext_addr, // External address
   output logic [2:0] ext_size, // External size code
   output logic [31:0] ext_wdata, // External write data
   input wire logic ext_ready, // External cycle done
   input wire logic [31:0] ext_rdata, // External read data
   input wire logic refresh_tick // One pulse per refresh
);

   typedef struct packed {
      bap_fsm_e st;
      logic [CTRL_ONE_W-1:0] ctrl1;
      logic graphics_mode_bit;
      logic err_rd;
      logic err_wr;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rsp_valid;
      logic rsp_err;
      logic [31:0] rsp_rdata;
      logic ext_valid;
      logic ext_write;
      logic ext_wr_strobe;
      logic [3:0] ext_space;
      logic [1:0] ext_rom_mode;
      logic [2:0] ext_rom_wait;
      logic ext_wait_prog;
      logic [31:0] ext_addr;
      logic [2:0] ext_size;
      logic [31:0] ext_wdata;
      logic invert;
      logic [1:0] ref_cnt;
   } bap_state_s;

   bap_state_s q;
   bap_state_s nxt;

   bap_chk_if chk ();

   bap_policy_check u_chk (
      .c (chk.chk)
   );

   assign chk.addr = req_addr;
   assign chk.size = req_size;
   assign chk.wr = req_write;
   assign chk.ctrl = q.ctrl1;

   // Byte-lane mask built from AXI strobes
   logic [31:0] wmask;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wmask[gi*8 +: 8] = {8{q.w_strb[gi]}};
      end
   endgenerate

   logic do_wr;
   logic wr_clr_wr;
   logic wr_clr_rd;
   logic set_wr;
   logic set_rd;
   logic lcd_inv;
   logic deadlock;
   logic bus_side;

   always_comb begin
      do_wr = q.aw_got && q.w_got && !q.bvalid;
      wr_clr_wr = do_wr && (q.aw_addr == OFS_ERR_STAT) &&
         q.w_strb[0] && q.w_data[ERR_WR_BIT]; // RULE_22
      wr_clr_rd = do_wr && (q.aw_addr == OFS_ERR_STAT) &&
         q.w_strb[0] && q.w_data[ERR_RD_BIT];
      lcd_inv = !q.ctrl1[LCD_OR_FAST_BUS_SELECT] &&
         !q.graphics_mode_bit; // RULE_16
      bus_side = (q.ext_space == SP_SIO) || (q.ext_space == SP_SMEM) ||
         (q.ext_space == SP_LCD) || (q.ext_space == SP_FAST);
      // Only system bus, LCD and fast bus cycles are timed out on a missing ready
      deadlock = q.st[1] && q.ext_valid && !ext_ready && bus_side &&
         refresh_tick &&
         (q.ref_cnt == DEADLOCK_REFRESHES - 2'h1); // RULE_17
   end

   always_comb begin
      nxt = q;
      set_wr = 1'b0;
      set_rd = 1'b0;
      nxt.rsp_valid = 1'b0;
      nxt.rsp_err = 1'b0;

      // AXI write channel: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         nxt.aw_got = 1'b1;
         nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt.w_got = 1'b1;
         nxt.w_data = s_axi_wdata;
         nxt.w_strb = s_axi_wstrb;
      end
      if (do_wr) begin
         nxt.aw_got = 1'b0;
         nxt.w_got = 1'b0;
         nxt.bvalid = 1'b1;
         nxt.bresp = RESP_OKAY;
         case (q.aw_addr)
            OFS_CTRL_ONE: begin
               nxt.ctrl1 = (q.ctrl1 & ~(wmask[10:0] & CTRL_ONE_WMASK)) |
                  (q.w_data[10:0] & wmask[10:0] & CTRL_ONE_WMASK);
            end
            OFS_CTRL_TWO: begin
               if (q.w_strb[0]) begin
                  nxt.graphics_mode_bit = q.w_data[GRAPHICS_MODE_BIT];
               end
            end
            OFS_ERR_STAT: ;
            default: nxt.bresp = RESP_SLVERR;
         endcase
      end
      if (q.bvalid && s_axi_bready) begin
         nxt.bvalid = 1'b0;
      end

      // AXI read channel
      if (s_axi_arvalid && s_axi_arready) begin
         nxt.rvalid = 1'b1;
         nxt.rresp = RESP_OKAY;
         nxt.rdata = 32'h0000_0000;
         case (s_axi_araddr)
            OFS_CTRL_ONE: nxt.rdata[10:0] = q.ctrl1;
            OFS_CTRL_TWO: nxt.rdata[GRAPHICS_MODE_BIT] = q.graphics_mode_bit;
            OFS_ERR_STAT: begin
               nxt.rdata[ERR_RD_BIT] = q.err_rd;
               nxt.rdata[ERR_WR_BIT] = q.err_wr;
               nxt.rdata[BUSY_BIT] = q.st[1];
            end
            default: nxt.rresp = RESP_SLVERR;
         endcase
      end
      if (q.rvalid && s_axi_rready) begin
         nxt.rvalid = 1'b0;
      end

      // Core request sequencing
      case (q.st)
         ST_IDLE: begin
            if (req_valid) begin
               if (chk.illegal || chk.space == SP_NONE ||
                   chk.space == SP_RSVD) begin
                  // No external cycle for a refused access
                  nxt.rsp_valid = 1'b1; // RULE_24
                  nxt.rsp_err = !req_write; // RULE_20 RULE_25
                  set_wr = req_write; // RULE_21 RULE_25
                  set_rd = !req_write;
               end else begin
                  nxt.st = ST_XFER;
                  nxt.ext_valid = 1'b1;
                  nxt.ext_write = req_write;
                  nxt.ext_wr_strobe = req_write &&
                     chk.wr_strobe_en; // RULE_12 RULE_09
                  nxt.ext_space = chk.space;
                  // Page mode narrows read devices to page ROM
                  nxt.ext_rom_mode = chk.rom_mode; // RULE_08
                  nxt.ext_wait_prog = chk.rom_mode != ROM_FLASH; // RULE_11
                  nxt.ext_rom_wait = (chk.rom_mode == ROM_FLASH) ?
                     FLASH_WAIT :
                     q.ctrl1[ROM_WAIT_LSB +: 3]; // RULE_11
                  nxt.ext_addr = req_addr;
                  nxt.ext_size = req_size;
                  nxt.invert = lcd_inv && (chk.space == SP_LCD);
                  nxt.ext_wdata = (lcd_inv && chk.space == SP_LCD) ?
                     ~req_wdata : req_wdata; // RULE_16
                  nxt.ref_cnt = 2'h0;
               end
            end
         end
         ST_XFER: begin
            if (ext_ready) begin
               nxt.st = ST_IDLE;
               nxt.ext_valid = 1'b0;
               nxt.ext_wr_strobe = 1'b0;
               nxt.rsp_valid = 1'b1;
               nxt.rsp_rdata = q.invert ? ~ext_rdata : ext_rdata; // RULE_16
            end else if (deadlock) begin
               nxt.st = ST_IDLE;
               nxt.ext_valid = 1'b0;
               nxt.ext_wr_strobe = 1'b0;
               nxt.rsp_valid = 1'b1;
               nxt.rsp_err = !q.ext_write; // RULE_17 RULE_20
               set_wr = q.ext_write; // RULE_17 RULE_21
               set_rd = !q.ext_write;
            end else if (refresh_tick && bus_side) begin
               nxt.ref_cnt = q.ref_cnt + 2'h1;
            end
         end
         default: begin
            nxt.st = ST_IDLE;
            nxt.ext_valid = 1'b0;
            nxt.ext_wr_strobe = 1'b0;
         end
      endcase

      // New errors win over a clear in the same cycle
      nxt.err_wr = set_wr | (q.err_wr & ~wr_clr_wr); // RULE_21 RULE_22
      nxt.err_rd = set_rd | (q.err_rd & ~wr_clr_rd);
   end

   // Every cycle and timing count advances on this one clock
   always_ff @(posedge core_clk) begin // RULE_23
      if (!rst_n) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.ctrl1 <= CTRL_ONE_RST; // RULE_10
      end else if (ce) begin
         q <= nxt;
      end
   end

   assign s_axi_awready = !q.aw_got && !q.bvalid;
   assign s_axi_wready = !q.w_got && !q.bvalid;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;

   assign req_ready = q.st[0] && ce;
   assign rsp_valid = q.rsp_valid;
   assign rsp_err = q.rsp_err;
   assign rsp_rdata = q.rsp_rdata;
   assign core_interrupt_zero = q.err_wr; // RULE_21

   assign ext_valid = q.ext_valid;
   assign ext_write = q.ext_write;
   assign ext_wr_strobe = q.ext_wr_strobe;
   assign ext_space = q.ext_space;
   assign ext_rom_mode = q.ext_rom_mode;
   assign ext_rom_wait = q.ext_rom_wait;
   assign ext_wait_prog = q.ext_wait_prog;
   assign ext_addr = q.ext_addr;
   assign ext_size = q.ext_size;
   assign ext_wdata = q.ext_wdata;

endmodule // bap_unit

/* File: src/bap_pkg.sv */
// Shared constants and types of the bus access policy unit.
// Assumes one core clock domain; all offsets are AXI4-Lite byte addresses.
package bap_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
   localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
   localparam logic [7:0] OFS_ERR_STAT = 8'h08;

   // bus_control_reg_one fields
   localparam int LOWER_BANK_FLASH_ENABLE = 0;
   localparam int LOWER_BANK_PAGE_SELECT = 1;
   localparam int UPPER_BANK_FLASH_ENABLE = 2;
   localparam int UPPER_BANK_PAGE_SELECT = 3;
   localparam int LCD_OR_FAST_BUS_SELECT = 4;
   localparam int BUS_WIDTH_32 = 5;
   localparam int ROM_WAIT_LSB = 8;
   localparam int CTRL_ONE_W = 11;
   localparam logic [10:0] CTRL_ONE_WMASK = 11'h73F;
   localparam logic [10:0] CTRL_ONE_RST = 11'h000;
   // bus_control_reg_two / bus_error_status_reg fields
   localparam int GRAPHICS_MODE_BIT = 0;
   localparam int ERR_RD_BIT = 0;
   localparam int ERR_WR_BIT = 1;
   localparam int BUSY_BIT = 2;

   // Physical address map
   localparam logic [31:0] DRAM_LO = 32'h0000_0000;
   localparam logic [31:0] DRAM_HI = 32'h03FF_FFFF;
   localparam logic [31:0] RSV1_LO = 32'h0400_0000;
   localparam logic [31:0] RSV1_HI = 32'h09FF_FFFF;
   localparam logic [31:0] LCD_LO = 32'h0A00_0000;
   localparam logic [31:0] LCD_HI = 32'h0AFF_FFFF;
   localparam logic [31:0] OCIO1_LO = 32'h0B00_0000;
   localparam logic [31:0] OCIO1_HI = 32'h0B7F_FFFF;
   localparam logic [31:0] OCIO2_LO = 32'h0B80_0000;
   localparam logic [31:0] OCIO2_HI = 32'h0BFF_FFFF;
   localparam logic [31:0] RSV2_LO = 32'h0C00_0000;
   localparam logic [31:0] RSV2_HI = 32'h0FFF_FFFF;
   localparam logic [31:0] SMEM_LO = 32'h1000_0000;
   localparam logic [31:0] SMEM_HI = 32'h13FF_FFFF;
   localparam logic [31:0] SIO_LO = 32'h1400_0000;
   localparam logic [31:0] SIO_HI = 32'h17FF_FFFF;
   localparam logic [31:0] ROM_LO = 32'h1800_0000;
   localparam logic [31:0] ROM_HI = 32'h1FFF_FFFF;
   localparam int ROM_PAIR_BIT = 26;

   // Transfer size codes; bit n of a mask allows code n
   localparam logic [2:0] SZ_1 = 3'h0;
   localparam logic [2:0] SZ_2 = 3'h1;
   localparam logic [2:0] SZ_3 = 3'h2;
   localparam logic [2:0] SZ_4 = 3'h3;
   localparam logic [2:0] SZ_8 = 3'h4;
   localparam logic [2:0] SZ_16 = 3'h5;
   localparam logic [5:0] MSK_ALL = 6'h3F;
   localparam logic [5:0] MSK_NO3 = 6'h3B;
   localparam logic [5:0] MSK_LCD = 6'h1B;
   localparam logic [5:0] MSK_OCIO2 = 6'h1A;

   localparam logic [1:0] ROM_ORD = 2'h0;
   localparam logic [1:0] ROM_PAGE = 2'h1;
   localparam logic [1:0] ROM_FLASH = 2'h2;
   localparam logic [2:0] FLASH_WAIT = 3'h0;
   localparam logic [1:0] DEADLOCK_REFRESHES = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      SP_NONE, SP_RSVD, SP_ROM, SP_SIO, SP_SMEM, SP_OCIO1, SP_OCIO2,
      SP_LCD, SP_FAST, SP_DRAM
   } bap_space_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_XFER = 2'b10
   } bap_fsm_e;

endpackage

/* File: src/bap_chk_if.sv */
// Carrier between the unit's top and its access decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/100ps
interface bap_chk_if;
   import bap_pkg::*;
   logic [31:0] addr;
   logic [2:0] size;
   logic wr;
   logic [CTRL_ONE_W-1:0] ctrl;
   bap_space_e space;
   logic illegal;
   logic [1:0] rom_mode;
   logic wr_strobe_en;
   modport main (output addr, size, wr, ctrl,
      input space, illegal, rom_mode, wr_strobe_en);
   modport chk (input addr, size, wr, ctrl,
      output space, illegal, rom_mode, wr_strobe_en);
endinterface

/* File: src/bap_policy_check.sv */
// Address space, ROM mode and transfer size decoder.
// Assumes the top holds the request stable while it samples the result.
`timescale 1ns/100ps
module bap_policy_check
   import bap_pkg::*;
(
   bap_chk_if.chk c // Request in, verdict out
);

   function automatic logic in_rng(input logic [31:0] a, lo, hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   logic [5:0] msk;
   logic fl_en;
   logic pg_sel;

   always_comb begin
      c.space = SP_NONE;
      if (in_rng(c.addr, RSV1_LO, RSV1_HI) ||
          in_rng(c.addr, RSV2_LO, RSV2_HI)) begin
         c.space = SP_RSVD; // RULE_18 RULE_19
      end else if (in_rng(c.addr, DRAM_LO, DRAM_HI)) begin
         c.space = SP_DRAM;
      end else if (in_rng(c.addr, LCD_LO, LCD_HI)) begin
         c.space = c.ctrl[LCD_OR_FAST_BUS_SELECT] ?
            SP_FAST : SP_LCD; // RULE_05
      end else if (in_rng(c.addr, OCIO1_LO, OCIO1_HI)) begin
         c.space = SP_OCIO1;
      end else if (in_rng(c.addr, OCIO2_LO, OCIO2_HI)) begin
         c.space = SP_OCIO2;
      end else if (in_rng(c.addr, SMEM_LO, SMEM_HI)) begin
         c.space = SP_SMEM;
      end else if (in_rng(c.addr, SIO_LO, SIO_HI)) begin
         c.space = SP_SIO;
      end else if (in_rng(c.addr, ROM_LO, ROM_HI)) begin
         c.space = SP_ROM;
      end
   end

   // Banks 3/2 and 1/0 each follow their own pair of bits
   always_comb begin
      fl_en = c.addr[ROM_PAIR_BIT] ? c.ctrl[UPPER_BANK_FLASH_ENABLE] :
         c.ctrl[LOWER_BANK_FLASH_ENABLE]; // RULE_06
      pg_sel = c.addr[ROM_PAIR_BIT] ? c.ctrl[UPPER_BANK_PAGE_SELECT] :
         c.ctrl[LOWER_BANK_PAGE_SELECT]; // RULE_06
      if (fl_en) begin
         c.rom_mode = ROM_FLASH; // RULE_07
      end else if (pg_sel) begin
         c.rom_mode = ROM_PAGE; // RULE_07
      end else begin
         c.rom_mode = ROM_ORD; // RULE_07
      end
   end

   always_comb begin
      c.wr_strobe_en = 1'b1;
      case (c.space)
         SP_ROM: begin
            if (!c.wr) begin
               msk = MSK_ALL; // RULE_01
            end else if (c.rom_mode == ROM_FLASH) begin
               msk = c.ctrl[BUS_WIDTH_32] ? 6'h08 : 6'h02; // RULE_04
            end else begin
               // Write cycle runs but never strobes the device
               msk = MSK_ALL;
               c.wr_strobe_en = 1'b0; // RULE_12 RULE_09
            end
         end
         SP_SIO, SP_SMEM, SP_OCIO1: msk = MSK_NO3; // RULE_02
         SP_OCIO2: msk = MSK_OCIO2; // RULE_03
         SP_LCD, SP_FAST: msk = MSK_LCD; // RULE_03 RULE_15
         SP_DRAM: msk = MSK_ALL; // RULE_01
         default: msk = 6'h00;
      endcase
      c.illegal = (c.size > SZ_16) || !msk[c.size]; // RULE_25
   end

endmodule // bap_policy_check

/* File: dv/bap_unit_monitor.sv */
// Concurrent checks on the policy unit's top ports.
// Assumes ce stays high while the core port is busy.
`timescale 1ns/100ps
module bap_unit_monitor
   import bap_pkg::*;
(
   input logic core_clk, // Clock
   input logic rst_n, // Reset
   input logic ce, // Enable
   input logic req_valid, // Request
   input logic req_ready, // Taken
   input logic req_write, // Write
   input logic [31:0] req_addr, // Address
   input logic [2:0] req_size, // Size code
   input logic rsp_valid, // Answer
   input logic rsp_err, // Bus error
   input logic core_interrupt_zero, // Interrupt
   input logic ext_valid, // Cycle on
   input logic ext_write, // Cycle write
   input logic ext_wr_strobe, // Strobe
   input logic [3:0] ext_space, // Space
   input logic [1:0] ext_rom_mode, // Mode
   input logic [2:0] ext_rom_wait, // Wait
   input logic ext_wait_prog // Wait prog
);
   logic take;
   assign take = req_valid && req_ready && ce;
   function automatic logic inr(logic [31:0] a, lo, hi);
      return a >= lo && a <= hi;
   endfunction
   default clocking dcb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_rsv2;
      take && inr(req_addr, RSV2_LO, RSV2_HI) |=> rsp_valid && !ext_valid;
   endproperty
   a_rsv2: assert property (p_rsv2)
      else $error("rsv2 cycle");
   property p_rsv1;
      take && inr(req_addr, RSV1_LO, RSV1_HI) |=> rsp_valid && !ext_valid;
   endproperty
   a_rsv1: assert property (p_rsv1)
      else $error("rsv1 cycle");
   property p_rderr;
      take && !req_write && (inr(req_addr, RSV1_LO, RSV1_HI) ||
         inr(req_addr, RSV2_LO, RSV2_HI)) |=> rsp_err;
   endproperty
   a_rderr: assert property (p_rderr)
      else $error("no rd err");
   property p_wrirq;
      take && req_write && inr(req_addr, RSV2_LO, RSV2_HI)
         |-> ##[1:3] core_interrupt_zero;
   endproperty
   a_wrirq: assert property (p_wrirq)
      else $error("no wr irq");
   property p_no3;
      take && req_size == SZ_3 && (inr(req_addr, SMEM_LO, SIO_HI) ||
         inr(req_addr, OCIO1_LO, OCIO1_HI)) |=> rsp_valid && !ext_valid;
   endproperty
   a_no3: assert property (p_no3)
      else $error("3B not refused");
   property p_ocio2;
      take && inr(req_addr, OCIO2_LO, OCIO2_HI) &&
         (req_size == SZ_1 || req_size == SZ_16) |=> !ext_valid;
   endproperty
   a_ocio2: assert property (p_ocio2)
      else $error("ocio2 size");
   property p_strobe;
      ext_valid && ext_write && ext_space == 4'(SP_ROM) &&
         ext_rom_mode == ROM_ORD |-> !ext_wr_strobe;
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("rom strobe");
   property p_flash;
      ext_valid && ext_space == 4'(SP_ROM) && ext_rom_mode == ROM_FLASH
         |-> !ext_wait_prog && ext_rom_wait == FLASH_WAIT;
   endproperty
   a_flash: assert property (p_flash)
      else $error("flash wait");
endmodule // bap_unit_monitor

bind bap_unit bap_unit_monitor mon_u (.*);

/* File: dv/bap_ext_model.sv */
// External cycle responder model.
// Assumes ext_valid holds until ext_ready is seen.
`timescale 1ns/100ps
module bap_ext_model #(
   parameter logic [31:0] PAT = 32'h5A5A_0F0F
) (
   input logic core_clk, // Clock
   input logic rst_n, // Reset
   input logic ext_valid, // Cycle on
   input logic [31:0] ext_addr, // Address
   input logic hang, // Never answer
   input logic [1:0] lat, // Extra wait
   output logic ext_ready = 0, // Done
   output logic [31:0] ext_rdata = 0 // Data
);
   logic [2:0] cnt = 0;
   always @(posedge core_clk) begin
      if (!rst_n || !ext_valid || ext_ready) begin
         cnt <= 0;
         ext_ready <= 0;
         ext_rdata <= ~ext_rdata;
      end else if (!hang && cnt >= lat) begin
         ext_ready <= 1;
         ext_rdata <= ext_addr ^ PAT;
      end else begin
         cnt <= cnt + 1;
         ext_rdata <= ~ext_rdata; // Stale data never looks valid
      end
   end
endmodule // bap_ext_model

/* File: dv/tb_bus_access_policy_unit.sv */
// Self-checking bench for the bus access policy unit.
// Assumes the responder model on the cycle port.
`timescale 1ns/100ps
module tb_bus_access_policy_unit;
   import bap_pkg::*;
   localparam logic [31:0] PAT = 32'h5A5A_0F0F;
   typedef struct {logic err, dk; logic [31:0] d;} bap_exp_s;
   logic core_clk = 0, rst_n = 0, ce = 1, refresh_tick = 0, hang = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, req_valid = 0, req_write = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [3:0] s_axi_wstrb = 4'hF, ext_space;
   logic [31:0] s_axi_wdata = 0, req_addr = 0, req_wdata = 0;
   logic [2:0] req_size = 0, ext_rom_wait, ext_size;
   logic [1:0] lat = 0, s_axi_bresp, s_axi_rresp, ext_rom_mode, rr;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, req_ready, rsp_valid, rsp_err, core_interrupt_zero;
   logic ext_valid, ext_write, ext_wr_strobe, ext_wait_prog, ext_ready;
   logic [31:0] s_axi_rdata, rsp_rdata, ext_addr, ext_wdata, ext_rdata;
   logic [31:0] rv, a, base[7], rsv[4];
   logic [5:0] msk[7];
   bap_exp_s q[$], e;
   int bad_count = 0, comparisons = 0, cyc = 0, i, j;

   always #2 core_clk = ~core_clk;
   bap_unit dut_u (.*);
   bap_ext_model #(.PAT(PAT)) ext_u (.*);

   task chk(input logic [31:0] g, x, input string m);
      comparisons++;
      if (g !== x) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge core_clk) begin
      if (++cyc == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   // Mid-cycle, clear of the launching edge
   always @(negedge core_clk) begin
      if (rst_n && rsp_valid) begin
         e = q.pop_front();
         chk(rsp_err, e.err, "err");
         if (e.dk) chk(rsp_rdata, e.d, "rdata");
      end
   end

   task req(input logic w, input logic [31:0] ad, input logic [2:0] s,
      input logic er, input logic dk, input logic [31:0] d);
      q.push_back('{er, dk, d});
      @(posedge core_clk);
      req_valid <= 1;
      req_write <= w;
      req_addr <= ad;
      req_size <= s;
      req_wdata <= d;
      lat <= 2'($urandom);
      do @(posedge core_clk); while (!req_ready);
      req_valid <= 0;
      while (q.size() != 0) @(posedge core_clk);
      @(posedge core_clk);
   endtask

   task wr(input logic [7:0] ad, input logic [31:0] d);
      logic ok_a, ok_w;
      {ok_a, ok_w} = 0;
      @(posedge core_clk);
      s_axi_awvalid <= 1;
      s_axi_awaddr <= ad;
      s_axi_wvalid <= 1;
      s_axi_wdata <= d;
      s_axi_bready <= 1;
      while (!(ok_a && ok_w)) begin
         @(posedge core_clk);
         if (s_axi_awready && !ok_a) begin
            ok_a = 1;
            s_axi_awvalid <= 0;
         end
         if (s_axi_wready && !ok_w) begin
            ok_w = 1;
            s_axi_wvalid <= 0;
         end
      end
      while (!s_axi_bvalid) @(posedge core_clk);
      rr = s_axi_bresp;
      s_axi_bready <= 0;
   endtask

   task rd(input logic [7:0] ad);
      @(posedge core_clk);
      s_axi_arvalid <= 1;
      s_axi_araddr <= ad;
      s_axi_rready <= 1;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge core_clk); while (!s_axi_rvalid);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 0;
   endtask

   initial begin
      void'($urandom(21204));
      base = '{ROM_LO, DRAM_LO, SMEM_LO, SIO_LO, OCIO1_LO, OCIO2_LO, LCD_LO};
      msk = '{MSK_ALL, MSK_ALL, MSK_NO3, MSK_NO3, MSK_NO3, MSK_OCIO2, MSK_LCD};
      rsv = '{RSV1_LO, RSV1_HI, RSV2_LO, RSV2_HI};
      repeat (3) @(posedge core_clk);
      rst_n <= 1;
      rd(OFS_CTRL_ONE);
      chk(rv, 32'(CTRL_ONE_RST), "ctl rst");
      rd(8'h0C);
      chk(rr, RESP_SLVERR, "unmapped");
      req(0, ROM_LO, SZ_4, 0, 1, ROM_LO ^ PAT);
      chk(ext_rom_mode, ROM_ORD, "rst mode");
      for (i = 0; i < 7; i++) for (j = 0; j < 6; j++) begin
         a = base[i] | ($urandom & 32'h000F_FFF0);
         req(0, a, 3'(j), !msk[i][j], msk[i][j],
            i == 6 ? ~(a ^ PAT) : a ^ PAT);
      end
      for (i = 0; i < 4; i++) req(0, rsv[i], SZ_4, 1, 0, 0);
      $display("sizes done");
      req(1, LCD_LO, SZ_2, 0, 0, 32'h0000_A5A5);
      chk(ext_wdata, 32'hFFFF_5A5A, "inv wr");
      wr(OFS_CTRL_TWO, 32'h0000_0001);
      req(0, LCD_LO, SZ_1, 0, 1, LCD_LO ^ PAT);
      wr(OFS_CTRL_ONE, 32'h0000_0010);
      req(0, LCD_LO, SZ_8, 0, 1, LCD_LO ^ PAT);
      chk(ext_space, 4'(SP_FAST), "fast bus");
      req(0, LCD_LO, SZ_16, 1, 0, 0);
      hang <= 1;
      fork
         req(0, SIO_LO, SZ_2, 1, 0, 0);
         repeat (2) begin
            repeat (4) @(posedge core_clk);
            refresh_tick <= 1;
            @(posedge core_clk);
            refresh_tick <= 0;
         end
      join
      hang <= 0;
      $display("lcd done");
      req(1, RSV2_LO, SZ_4, 0, 0, 0);
      chk(core_interrupt_zero, 1, "wr irq");
      rd(OFS_ERR_STAT);
      chk(rv[1:0], 2'b11, "err stat");
      wr(OFS_ERR_STAT, 32'h0000_0003);
      @(posedge core_clk);
      chk(core_interrupt_zero, 0, "irq clr");
      req(1, OCIO2_LO, SZ_1, 0, 0, 0);
      chk(core_interrupt_zero, 1, "size irq");
      wr(OFS_ERR_STAT, 32'h0000_0002);
      req(1, ROM_LO, SZ_4, 0, 0, $urandom);
      wr(OFS_CTRL_ONE, 32'h0000_0021);
      req(1, ROM_LO, SZ_4, 0, 0, $urandom);
      chk(ext_rom_mode, ROM_FLASH, "flash mode");
      chk(core_interrupt_zero, 0, "flash ok");
      req(1, ROM_LO, SZ_2, 0, 0, 0);
      chk(core_interrupt_zero, 1, "width");
      wr(OFS_ERR_STAT, 32'h0000_0002);
      wr(OFS_CTRL_ONE, 32'h0000_0508);
      req(0, ROM_HI, SZ_16, 0, 1, ROM_HI ^ PAT);
      chk(ext_rom_mode, ROM_PAGE, "page mode");
      chk({ext_wait_prog, ext_rom_wait}, 4'hD, "wait set");
      req(0, ROM_LO, SZ_3, 0, 1, ROM_LO ^ PAT);
      chk(ext_rom_mode, ROM_ORD, "lower pair");
      wr(OFS_CTRL_ONE, 32'h0000_000C);
      req(0, ROM_HI, SZ_1, 0, 1, ROM_HI ^ PAT);
      chk(ext_rom_mode, ROM_FLASH, "flash over page");
      $display("rom done");
      tally_and_finish();
   end
endmodule // tb_bus_access_policy_unit
